// ===== rtl/radio_device.sv
// Function
// RULE_01: Response wait turns radio around after transmit
// RULE_02: Insert turnaround delay before receiver on
// RULE_03: Response wait clears at receiver on/abort
// RULE_04: Host sets response wait with transmit go
// RULE_05: Receiver on command starts preamble search
// RULE_06: Receiver on command self-clears when seen
// RULE_07: Receiver waits 16 us startup delay
// RULE_08: Timed receive catches preamble at scheduled time
// RULE_09: Host programs time before timed receive
// RULE_10: Toggle write swaps host receive buffer half
// RULE_11: Flag reports host receive buffer half
// RULE_12: Interrupt when masked flag bits coincide
// RULE_13: Mask clear or flag W1C removes interrupt
// RULE_14: Transmit go starts frame, clears at start
// RULE_15: Abort returns to idle and self-clears
// RULE_16: Reserved mask bits inert, read zero
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module radio_device
  import radio_ctl_pkg::*;
#(
  parameter int DELAY_W = 20
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Sync reset, active low
  radio_reg_if.device regs, // Register link from host
  input wire logic [31:0] sys_time, // Free-running time in cycles
  input wire logic [31:0] scheduled_action_time, // Delayed action time
  input wire logic [DELAY_W-1:0] turnaround_delay_value, // Turnaround cycles
  input wire logic tx_done, // Frame finished transmitting
  input wire logic rx_done, // Reception finished
  input wire logic [31:0] event_in, // Event pulses to latch
  output logic tx_begin, // Pulse: frame transmission starts
  output logic tx_active, // Transmitter on
  output logic rx_power, // Receiver powered
  output logic preamble_search, // Receiver taking preamble symbols
  output logic radio_abort, // Pulse: activity aborted
  output logic host_buffer_half // Half the host reads
);

  // ------------------------------------------------------------
  // Register link decode
  // ------------------------------------------------------------
  wire ctl_wr = regs.wr_en && (regs.addr == SYSTEM_CONTROL_IDX);
  wire mask_wr = regs.wr_en && (regs.addr == EVENT_INTERRUPT_MASK_IDX);
  wire flags_wr = regs.wr_en && (regs.addr == EVENT_FLAGS_IDX);

  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] mask_q;
  logic [31:0] flags_q;
  logic [31:0] rdata_q;
  logic rd_valid_q;
  logic half_q;
  logic irq_q;
  radio_state_e state_q, state_d;
  logic [DELAY_W-1:0] turn_q, turn_d;
  logic [11:0] warm_q, warm_d;
  logic tx_begin_d;
  logic tx_begin_q;
  logic abort_q;
  logic [31:0] hw_clr;

  wire go = ctrl_q[TRANSMIT_GO_BIT];
  wire timed_tx = ctrl_q[TIMED_TRANSMIT_BIT];
  wire abort = ctrl_q[RADIO_ABORT_TO_IDLE_BIT];
  wire resp_wait = ctrl_q[RESPONSE_WAIT_CTL_BIT];
  wire rx_cmd = ctrl_q[RECEIVER_ON_CMD_BIT];
  wire timed_rx = ctrl_q[TIMED_RECEIVER_ON_BIT];
  wire [31:0] rx_on_time = scheduled_action_time - 32'(RX_STARTUP_CYC);
  wire [11:0] warm_full = 12'(RX_STARTUP_CYC - 1);
  wire toggle_wr = ctl_wr && regs.wdata[HOST_BUFFER_HALF_TOGGLE_BIT];

  // ------------------------------------------------------------
  // Radio sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    turn_d = turn_q;
    warm_d = warm_q;
    hw_clr = RESET_WORD;
    tx_begin_d = 1'b0;
    if (abort) begin
      state_d = ST_IDLE; // RULE_15
      hw_clr = CONTROL_STORED; // RULE_03 RULE_15
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (go && timed_tx) begin
            state_d = ST_TX_WAIT;
          end else if (go) begin
            tx_begin_d = 1'b1; // RULE_14
            hw_clr = bit_word(TRANSMIT_GO_BIT);
            state_d = ST_TX;
          end else if (rx_cmd) begin
            hw_clr = bit_word(RECEIVER_ON_CMD_BIT)
              | bit_word(TIMED_RECEIVER_ON_BIT); // RULE_06
            warm_d = warm_full;
            state_d = timed_rx ? ST_RX_WAIT : ST_WARM; // RULE_05 RULE_08
          end
        end
        ST_TX_WAIT: begin
          if (sys_time == scheduled_action_time) begin
            tx_begin_d = 1'b1;
            hw_clr = bit_word(TRANSMIT_GO_BIT) | bit_word(TIMED_TRANSMIT_BIT); // RULE_14
            state_d = ST_TX;
          end
        end
        ST_TX: begin
          if (tx_done && resp_wait) begin
            turn_d = turnaround_delay_value; // RULE_02
            state_d = ST_TURN; // RULE_01
          end else if (tx_done) begin
            state_d = ST_IDLE;
          end
        end
        ST_TURN: begin
          if (turn_q == '0) begin
            hw_clr = bit_word(RESPONSE_WAIT_CTL_BIT); // RULE_03
            warm_d = warm_full;
            state_d = ST_WARM; // RULE_01
          end else begin
            turn_d = turn_q - 1'b1; // RULE_02
          end
        end
        ST_RX_WAIT: begin
          if (sys_time == rx_on_time) begin
            state_d = ST_WARM; // RULE_08
          end
        end
        ST_WARM: begin
          if (warm_q == '0) begin
            state_d = ST_RX; // RULE_07
          end else begin
            warm_d = warm_q - 1'b1; // RULE_07
          end
        end
        ST_RX: begin
          if (rx_done) begin
            state_d = ST_IDLE;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Control register: a host write wins over a hardware clear
  // ------------------------------------------------------------
  always_comb begin
    if (ctl_wr) begin
      ctrl_d = regs.wdata & CONTROL_STORED; // RULE_04
    end else begin
      ctrl_d = ctrl_q & ~hw_clr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      ctrl_q <= RESET_WORD;
      turn_q <= '0;
      warm_q <= '0;
      tx_begin_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      turn_q <= turn_d;
      warm_q <= warm_d;
      tx_begin_q <= tx_begin_d;
      abort_q <= abort; // RULE_15
    end
  end

  // ------------------------------------------------------------
  // Mask, flags, buffer half, interrupt
  // ------------------------------------------------------------
  wire [31:0] hw_events = event_in | (tx_begin_d ? bit_word(TX_BEGIN_EVT_BIT) : RESET_WORD)
    | ((state_q == ST_TX && tx_done) ? bit_word(TX_SENT_EVT_BIT) : RESET_WORD);
  wire [31:0] flags_view = (flags_q & FLAGS_LATCHED)
    | (half_q ? bit_word(HOST_BUFFER_HALF_FLAG_BIT) : RESET_WORD); // RULE_11
  wire [31:0] flags_clr = flags_wr ? regs.wdata : RESET_WORD;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= RESET_WORD;
      flags_q <= RESET_WORD;
      half_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      if (mask_wr) begin
        mask_q <= regs.wdata & MASK_WRITABLE; // RULE_16
      end
      flags_q <= ((flags_q & ~flags_clr) | hw_events) & FLAGS_LATCHED; // RULE_13
      if (toggle_wr) begin
        half_q <= ~half_q; // RULE_10
      end
      irq_q <= |(mask_q & flags_q & FLAGS_LATCHED); // RULE_12 RULE_13 RULE_16
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  wire [31:0] rd_mux = (regs.addr == SYSTEM_CONTROL_IDX) ? ctrl_q :
    (regs.addr == EVENT_INTERRUPT_MASK_IDX) ? mask_q :
    (regs.addr == EVENT_FLAGS_IDX) ? flags_view : RESET_WORD;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= RESET_WORD;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= regs.rd_en;
      if (regs.rd_en) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign regs.rdata = rdata_q;
  assign regs.rd_valid = rd_valid_q;
  assign regs.irq = irq_q;
  assign tx_begin = tx_begin_q;
  assign tx_active = (state_q == ST_TX);
  assign rx_power = (state_q == ST_WARM) || (state_q == ST_RX);
  assign preamble_search = (state_q == ST_RX); // RULE_05
  assign radio_abort = abort_q;
  assign host_buffer_half = half_q;

endmodule

// ===== rtl/radio_ctl_pkg.sv
package radio_ctl_pkg;

  // ------------------------------------------------------------
  // Device register map (index on the register link)
  // ------------------------------------------------------------
  localparam logic [7:0] SYSTEM_CONTROL_IDX = 8'h0d;
  localparam logic [7:0] EVENT_INTERRUPT_MASK_IDX = 8'h0e;
  localparam logic [7:0] EVENT_FLAGS_IDX = 8'h0f;

  // ------------------------------------------------------------
  // Control field positions
  // ------------------------------------------------------------
  localparam int TRANSMIT_GO_BIT = 1;
  localparam int TIMED_TRANSMIT_BIT = 2;
  localparam int RADIO_ABORT_TO_IDLE_BIT = 6;
  localparam int RESPONSE_WAIT_CTL_BIT = 7;
  localparam int RECEIVER_ON_CMD_BIT = 8;
  localparam int TIMED_RECEIVER_ON_BIT = 9;
  localparam int HOST_BUFFER_HALF_TOGGLE_BIT = 24;
  localparam logic [31:0] CONTROL_STORED = 32'h0000_03c6;

  // ------------------------------------------------------------
  // Event flag positions and mask layout
  // ------------------------------------------------------------
  localparam int TX_BEGIN_EVT_BIT = 4;
  localparam int TX_SENT_EVT_BIT = 7;
  localparam int HOST_BUFFER_HALF_FLAG_BIT = 30;
  localparam logic [31:0] MASK_WRITABLE = 32'h3ff7_fffe;
  localparam logic [31:0] FLAGS_LATCHED = 32'h3ff7_fffe;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RX_STARTUP_PS = 16000000;
  localparam int RX_STARTUP_CYC = (RX_STARTUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ------------------------------------------------------------
  // Host-side register map (AXI4-Lite byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] H_ADDR_OFS = 8'h00;
  localparam logic [7:0] H_WDATA_OFS = 8'h04;
  localparam logic [7:0] H_CMD_OFS = 8'h08;
  localparam logic [7:0] H_RDATA_OFS = 8'h0c;
  localparam logic [7:0] H_STATUS_OFS = 8'h10;
  localparam int H_CMD_WRITE_BIT = 0;
  localparam int H_CMD_READ_BIT = 1;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_TX_WAIT,
    ST_TX,
    ST_TURN,
    ST_RX_WAIT,
    ST_WARM,
    ST_RX
  } radio_state_e;

  function automatic logic [31:0] bit_word(input int pos);
    bit_word = 32'h0000_0001 << pos;
  endfunction

endpackage

// ===== rtl/radio_reg_if.sv
`timescale 1ns/1ps
interface radio_reg_if;
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic rd_valid;
  logic irq;

  modport device (
    input wr_en, rd_en, addr, wdata,
    output rdata, rd_valid, irq
  );
  modport host (
    output wr_en, rd_en, addr, wdata,
    input rdata, rd_valid, irq
  );
endinterface

// ===== rtl/radio_host.sv
`timescale 1ns/1ps
module radio_host
  import radio_ctl_pkg::*;
(
  input wire logic aclk, // System clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic irq_out, // Device interrupt level
  radio_reg_if.host link // Register link to device
);

  // ------------------------------------------------------------
  // AXI4-Lite write path
  // ------------------------------------------------------------
  logic aw_have_q, w_have_q, bvalid_q, ar_have_q, rvalid_q;
  logic [7:0] awaddr_q, araddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] dev_addr_q;
  logic [31:0] dev_wdata_q, dev_rdata_q;
  logic busy_q, wr_en_q, rd_en_q;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_have_q && w_have_q && !bvalid_q;
  wire wr_known = (awaddr_q == H_ADDR_OFS) || (awaddr_q == H_WDATA_OFS)
    || (awaddr_q == H_CMD_OFS);
  wire [31:0] strb_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire cmd_wr = do_write && (awaddr_q == H_CMD_OFS) && !busy_q;
  wire start_wr = cmd_wr && wdata_q[H_CMD_WRITE_BIT];
  wire start_rd = cmd_wr && !wdata_q[H_CMD_WRITE_BIT] && wdata_q[H_CMD_READ_BIT];

  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= RESET_WORD;
      bresp_q <= AXI_OKAY;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata & strb_mask;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? AXI_OKAY : AXI_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Device link: one write or one read, each forwarded whole
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dev_addr_q <= '0;
      dev_wdata_q <= RESET_WORD;
      dev_rdata_q <= RESET_WORD;
      busy_q <= 1'b0;
      wr_en_q <= 1'b0;
      rd_en_q <= 1'b0;
    end else begin
      wr_en_q <= start_wr; // RULE_04
      rd_en_q <= start_rd;
      if (do_write && awaddr_q == H_ADDR_OFS) begin
        dev_addr_q <= wdata_q[7:0];
      end
      if (do_write && awaddr_q == H_WDATA_OFS) begin
        dev_wdata_q <= wdata_q;
      end
      if (start_rd) begin
        busy_q <= 1'b1;
      end else if (link.rd_valid) begin
        busy_q <= 1'b0;
        dev_rdata_q <= link.rdata;
      end
    end
  end

  assign link.wr_en = wr_en_q;
  assign link.rd_en = rd_en_q;
  assign link.addr = dev_addr_q;
  assign link.wdata = dev_wdata_q;
  assign irq_out = link.irq; // RULE_12

  // ------------------------------------------------------------
  // AXI4-Lite read path
  // ------------------------------------------------------------
  wire [31:0] status_word = {30'h0000_0000, link.irq, busy_q};
  wire [31:0] rd_mux = (araddr_q == H_ADDR_OFS) ? {24'h00_0000, dev_addr_q} :
    (araddr_q == H_WDATA_OFS) ? dev_wdata_q :
    (araddr_q == H_RDATA_OFS) ? dev_rdata_q :
    (araddr_q == H_STATUS_OFS) ? status_word :
    (araddr_q == H_CMD_OFS) ? RESET_WORD : 32'hdead_beef;
  wire rd_known = (araddr_q == H_ADDR_OFS) || (araddr_q == H_WDATA_OFS)
    || (araddr_q == H_RDATA_OFS) || (araddr_q == H_STATUS_OFS) || (araddr_q == H_CMD_OFS);

  assign s_axi_arready = !ar_have_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_have_q <= 1'b0;
      araddr_q <= '0;
      rvalid_q <= 1'b0;
      rdata_q <= RESET_WORD;
      rresp_q <= AXI_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        ar_have_q <= 1'b1;
        araddr_q <= s_axi_araddr;
      end else if (ar_have_q && !rvalid_q) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_known ? rd_mux : RESET_WORD;
        rresp_q <= rd_known ? AXI_OKAY : AXI_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
        ar_have_q <= 1'b0;
      end
    end
  end

endmodule

// ===== dv/radio_ctl_props.sv
`timescale 1ns/1ps
module radio_ctl_props
  import radio_ctl_pkg::*;
(
  input wire logic aclk, // System clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic wr_en, // Link write strobe
  input wire logic rd_en, // Link read strobe
  input wire logic [7:0] addr, // Link register index
  input wire logic [31:0] wdata, // Link write data
  input wire logic [31:0] rdata, // Link read data
  input wire logic rd_valid, // Link read answer
  input wire logic irq // Interrupt level
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ------------------------------------------------------------
  // Shadow of the writable mask bits
  // ------------------------------------------------------------
  logic [31:0] shadow_q;
  logic [31:0] shadow_d;
  wire mask_wr = wr_en && addr == EVENT_INTERRUPT_MASK_IDX;
  assign shadow_d = mask_wr ? (wdata & MASK_WRITABLE) : shadow_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) shadow_q <= RESET_WORD;
    else shadow_q <= shadow_d;
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  AST_READ_ANSWER: assert property (rd_en |=> rd_valid)
    else $error("read strobe without answer next cycle");
  AST_ANSWER_CAUSE: assert property (rd_valid |-> $past(rd_en))
    else $error("read answer without a read strobe");
  AST_WRITE_PULSE: assert property (wr_en |=> !wr_en)
    else $error("write strobe longer than one cycle");
  AST_ONE_KIND: assert property (wr_en |-> !rd_en)
    else $error("write and read strobes together");
  AST_RDATA_HOLD: assert property (!rd_valid |-> $stable(rdata))
    else $error("read data moved without an answer");
  AST_MASK_READBACK: assert property (
    rd_valid && $past(addr) == EVENT_INTERRUPT_MASK_IDX |-> rdata == shadow_q)
    else $error("mask read back differs from writable bits");
  AST_MASK_ZERO_QUIET: assert property (
    mask_wr && (wdata & MASK_WRITABLE) == 32'h0000_0000 |-> ##2 !irq)
    else $error("interrupt stays after mask cleared");
  AST_NO_MASK_NO_IRQ: assert property (
    shadow_q == 32'h0000_0000 && $past(shadow_q) == 32'h0000_0000 |-> !irq)
    else $error("interrupt with empty mask");
endmodule

// ===== dv/radio_control_and_event_mask_bench.sv
`timescale 1ns/1ps
module radio_control_and_event_mask_bench;
  import radio_ctl_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, sys_time, scheduled_action_time = 0, event_in = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq_out, tx_done = 0, rx_done = 0, tx_begin, tx_active, rx_power;
  logic preamble_search, radio_abort, host_buffer_half;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [19:0] turnaround_delay_value = 20'h0_000a;
  int mismatches = 0, n_checks = 0, cyc = 0, n_txb = 0, n_abort = 0;

  always #2.5 aclk = ~aclk;
  radio_reg_if link();
  radio_host u_radio_host (.*);
  radio_device u_radio_device (.regs(link), .*);
  radio_ctl_props u_radio_ctl_props (.aclk(aclk), .aresetn(aresetn), .wr_en(link.wr_en),
    .rd_en(link.rd_en), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
    .rd_valid(link.rd_valid), .irq(link.irq));

  // ------------------------------------------------------------
  // Time base, pulse counters, watchdog
  // ------------------------------------------------------------
  always @(posedge aclk) sys_time <= aresetn ? sys_time + 1 : 32'h0000_0000;
  always @(negedge aclk) begin
    if (tx_begin === 1'b1) n_txb++;
    if (radio_abort === 1'b1) n_abort++;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      close_out();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rng(input string what, input int n, input int lo, input int hi);
    check(what, 32'(n >= lo && n <= hi), 32'h0000_0001);
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: pick = tx_active;
      1: pick = rx_power;
      2: pick = preamble_search;
      default: pick = irq_out;
    endcase
  endfunction
  task automatic count_to(input int w, output int n);
    n = 0;
    while (pick(w) !== 1'b1 && n < 20000) begin
      @(negedge aclk);
      n++;
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    aw_ok = 0;
    w_ok = 0;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1;
        s_axi_awvalid <= 0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic dev_wr(input logic [7:0] i, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(H_ADDR_OFS, {24'h00_0000, i}, r);
    axi_wr(H_WDATA_OFS, d, r);
    axi_wr(H_CMD_OFS, 32'h0000_0001, r);
    repeat (3) @(negedge aclk);
  endtask
  task automatic dev_rd(input logic [7:0] i, output logic [31:0] d);
    logic [1:0] r;
    logic [31:0] s;
    axi_wr(H_ADDR_OFS, {24'h00_0000, i}, r);
    axi_wr(H_CMD_OFS, 32'h0000_0002, r);
    do axi_rd(H_STATUS_OFS, s, r); while (s[0] !== 1'b0);
    axi_rd(H_RDATA_OFS, d, r);
  endtask
  task automatic evt(input logic [31:0] d);
    @(posedge aclk) event_in <= d;
    @(posedge aclk) event_in <= 32'h0000_0000;
    repeat (3) @(negedge aclk);
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  logic [31:0] d;
  logic [1:0] r;
  int n;
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    dev_rd(EVENT_INTERRUPT_MASK_IDX, d);
    check("mask reset", d, RESET_WORD);
    axi_wr(8'h20, 32'h0000_0001, r);
    check("bad addr wr", 32'(r), 32'(AXI_SLVERR));
    axi_rd(8'h20, d, r);
    check("bad addr rd", 32'(r), 32'(AXI_SLVERR));
    $display("test access done");
    dev_wr(EVENT_INTERRUPT_MASK_IDX, 32'hffff_ffff);
    dev_rd(EVENT_INTERRUPT_MASK_IDX, d);
    check("mask rw", d, MASK_WRITABLE);
    dev_wr(EVENT_INTERRUPT_MASK_IDX, 32'h0000_0010);
    evt(32'h0000_0010);
    check("irq set", 32'(irq_out), 32'h0000_0001);
    dev_wr(EVENT_FLAGS_IDX, 32'h0000_0010);
    check("irq w1c", 32'(irq_out), 32'h0000_0000);
    evt(32'h0000_0010);
    check("irq again", 32'(irq_out), 32'h0000_0001);
    dev_wr(EVENT_INTERRUPT_MASK_IDX, 32'h0000_0000);
    check("irq mask", 32'(irq_out), 32'h0000_0000);
    dev_wr(EVENT_INTERRUPT_MASK_IDX, ~MASK_WRITABLE);
    evt(32'hffff_ffff);
    check("irq rsvd", 32'(irq_out), 32'h0000_0000);
    dev_wr(EVENT_FLAGS_IDX, 32'hffff_ffff);
    $display("test interrupt done");
    dev_wr(SYSTEM_CONTROL_IDX, 32'h0000_0002);
    count_to(0, n);
    check("tx begun", 32'(n_txb), 32'h0000_0001);
    dev_rd(SYSTEM_CONTROL_IDX, d);
    check("go clear", d, 32'h0000_0000);
    @(posedge aclk) tx_done <= 1;
    @(posedge aclk) tx_done <= 0;
    repeat (3) @(negedge aclk);
    check("no turn", 32'({tx_active, rx_power}), 32'h0000_0000);
    $display("test transmit done");
    dev_wr(SYSTEM_CONTROL_IDX, 32'h0000_0082);
    count_to(0, n);
    @(posedge aclk) tx_done <= 1;
    @(posedge aclk) tx_done <= 0;
    count_to(1, n);
    rng("turn delay", n, 10, 13);
    check("tx off", 32'(tx_active), 32'h0000_0000);
    count_to(2, n);
    rng("warm", n, RX_STARTUP_CYC - 1, RX_STARTUP_CYC + 1);
    dev_rd(SYSTEM_CONTROL_IDX, d);
    check("wait clear", d, 32'h0000_0000);
    @(posedge aclk) rx_done <= 1;
    @(posedge aclk) rx_done <= 0;
    dev_wr(SYSTEM_CONTROL_IDX, 32'h0000_0082);
    count_to(0, n);
    // The abort write keeps the wait bit set, so only the abort can clear it
    dev_wr(SYSTEM_CONTROL_IDX, 32'h0000_00c0);
    check("abort tx", 32'(tx_active), 32'h0000_0000);
    dev_rd(SYSTEM_CONTROL_IDX, d);
    check("abort clr", d, 32'h0000_0000);
    $display("test turnaround done");
    dev_wr(SYSTEM_CONTROL_IDX, 32'h0000_0100);
    check("rx power", 32'(rx_power), 32'h0000_0001);
    count_to(2, n);
    rng("rx warm", n, RX_STARTUP_CYC - 6, RX_STARTUP_CYC);
    dev_rd(SYSTEM_CONTROL_IDX, d);
    check("rx clear", d, 32'h0000_0000);
    dev_wr(SYSTEM_CONTROL_IDX, 32'h0000_0040);
    check("abort rx", 32'({rx_power, preamble_search}), 32'h0000_0000);
    check("abort pulses", 32'(n_abort), 32'h0000_0002);
    $display("test receive done");
    @(posedge aclk) scheduled_action_time <= sys_time + 32'h0000_0064;
    dev_wr(SYSTEM_CONTROL_IDX, 32'h0000_0006);
    check("timed tx idle", 32'(tx_active), 32'h0000_0000);
    count_to(0, n);
    rng("timed tx", int'(sys_time - scheduled_action_time), 0, 2);
    dev_rd(SYSTEM_CONTROL_IDX, d);
    check("timed tx clr", d, 32'h0000_0000);
    dev_wr(SYSTEM_CONTROL_IDX, 32'h0000_0040);
    $display("test timed transmit done");
    @(posedge aclk) scheduled_action_time <= sys_time + 32'h0000_1770;
    dev_wr(SYSTEM_CONTROL_IDX, 32'h0000_0300);
    check("timed idle", 32'(rx_power), 32'h0000_0000);
    count_to(2, n);
    rng("timed", int'(sys_time - scheduled_action_time), 0, 2);
    dev_wr(SYSTEM_CONTROL_IDX, 32'h0000_0040);
    $display("test timed receive done");
    check("half rst", 32'(host_buffer_half), 32'h0000_0000);
    for (int k = 1; k <= 2; k++) begin
      dev_wr(SYSTEM_CONTROL_IDX, 32'h0100_0000);
      check("half", 32'(host_buffer_half), 32'(k % 2));
      dev_rd(EVENT_FLAGS_IDX, d);
      check("half flag", 32'(d[HOST_BUFFER_HALF_FLAG_BIT]), 32'(k % 2));
    end
    dev_rd(SYSTEM_CONTROL_IDX, d);
    check("toggle rd", d, 32'h0000_0000);
    $display("test buffer done");
    close_out();
  end
endmodule
